// File: acis_sequencer.sv
// module: automatic cycle interval sequencer with apb register slave
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - eight-bit cycle timer register written by host enables cycle mode if any config channel bit is set.
// - nonzero low three bits give one conversion per selected interval.
// - converter powers down after each conversion until next one due.
// - zero low three bits leave cycle mode; conversions stop.
// - channels converted are those enabled in config bits seven to four.
// - enabled channels converted lowest first, one per interval.
// - after highest channel wrap to lowest, loop until timer or config channel bits cleared.
module acis_sequencer
  import acis_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   adc_power_up,
  output logic                   adc_start,
  output logic      [1:0]        adc_channel,
  input  wire logic              adc_done,
  input  wire logic [RES_W-1:0]  adc_result
);
  // =====================================================================
  // registers and state
  logic [7:0]       conversion_interval_timer;
  logic [7:0]       config_reg;
  logic [RES_W-1:0] last_result;
  logic [1:0]       last_channel;
  logic [BUSY_W-1:0] wait_count;
  logic             done_s1;
  logic             done_s2;
  acis_state_e      state;
  acis_state_e      next_state;
  logic [1:0]       next_channel;

  acis_tmr_if tmr_bus();

  acis_interval_timer u_timer
  (
    .clk     (clk),
    .reset_n (reset_n),
    .tmr     (tmr_bus.tmr)
  );

  // =====================================================================
  // apb decode
  wire logic access   = psel && penable;
  wire logic wr       = access && pwrite;
  wire logic hit_ct   = (paddr == ADDR_CYCLE_TIMER);
  wire logic hit_cfg  = (paddr == ADDR_CONFIG);
  wire logic hit_st   = (paddr == ADDR_STATUS);
  wire logic hit_res  = (paddr == ADDR_RESULT);
  wire logic mapped   = hit_ct || hit_cfg || hit_st || hit_res;

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // =====================================================================
  // channel selection
  wire logic [2:0]        code    =
    conversion_interval_timer[CODE_MSB:CODE_LSB];
  wire logic [NUM_CH-1:0] ch_en   = config_reg[CH_MSB:CH_LSB];
  wire logic              cyc_on  = (code != CODE_OFF) && (ch_en != '0);

  // lowest enabled channel strictly above 'from', else wrap to lowest
  function automatic logic [1:0] pick_next(input logic [NUM_CH-1:0] en,
                                           input logic [1:0] from,
                                           input logic first);
    logic [1:0] lowest;
    logic [1:0] above;
    logic       found;
    lowest = 2'd0;
    above  = 2'd0;
    found  = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      if (en[i])
        lowest = 2'(i);
      if (en[i] && !first && (2'(i) > from))
      begin
        above = 2'(i);
        found = 1'b1;
      end
    end
    pick_next = found ? above : lowest;
  endfunction

  logic first_conv;
  wire logic [1:0] chosen = pick_next(ch_en, adc_channel, first_conv);

  assign tmr_bus.code    = cyc_on ? code : CODE_OFF;
  assign tmr_bus.restart = (state == ST_IDLE);

  // =====================================================================
  // sequencer next state
  wire logic wait_over = (wait_count == '0);

  always_comb
  begin
    next_state   = state;
    next_channel = adc_channel;
    unique case (state)
      ST_IDLE:
        if (cyc_on)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (!cyc_on)
          next_state = ST_IDLE;
        else if (tmr_bus.due)
        begin
          next_state   = ST_WAKE;
          next_channel = chosen;
        end
      ST_WAKE:
        if (wait_over)
          next_state = ST_CONV;
      ST_CONV:
        if (done_s2 || wait_over)
          next_state = cyc_on ? ST_SLEEP : ST_IDLE;
    endcase
  end

  // =====================================================================
  // sequencer registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state       <= ST_IDLE;
      adc_channel <= 2'd0;
      first_conv  <= 1'b1;
      wait_count  <= '0;
    end
    else
    begin
      state       <= next_state;
      adc_channel <= next_channel;
      if (state == ST_IDLE)
        first_conv <= 1'b1;
      else if (state == ST_CONV && next_state != ST_CONV)
        first_conv <= 1'b0;
      if (state == ST_SLEEP && next_state == ST_WAKE)
        wait_count <= BUSY_W'(POWERUP_CYC - 1);
      else if (state == ST_WAKE && next_state == ST_CONV)
        wait_count <= BUSY_W'(CONV_CYC + CONV_CYC - 1);
      else if (!wait_over)
        wait_count <= wait_count - 8'h01;
    end
  end

  // =====================================================================
  // converter control outputs
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      adc_power_up <= 1'b0;
      adc_start    <= 1'b0;
      done_s1      <= 1'b0;
      done_s2      <= 1'b0;
      last_result  <= '0;
      last_channel <= 2'd0;
    end
    else
    begin
      adc_power_up <= (next_state == ST_WAKE) ||
                      (next_state == ST_CONV);
      adc_start    <= (state == ST_WAKE) && (next_state == ST_CONV);
      done_s1      <= adc_done;
      done_s2      <= done_s1;
      if (state == ST_CONV && done_s2)
      begin
        last_result  <= adc_result;
        last_channel <= adc_channel;
      end
    end
  end

  // =====================================================================
  // register writes
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      conversion_interval_timer <= CYCLE_RESET;
      config_reg                <= CONFIG_RESET;
    end
    else
    begin
      if (wr && hit_ct)
        conversion_interval_timer <= pwdata[7:0];
      if (wr && hit_cfg)
        config_reg <= pwdata[7:0];
    end
  end

  // =====================================================================
  // read data
  wire logic [31:0] status_word = {26'h000_0000, state, adc_channel,
                                   adc_power_up, cyc_on};
  wire logic [31:0] result_word = {18'h0_0000, last_channel, last_result};
  wire logic [31:0] read_mux =
    hit_ct  ? {24'h00_0000, conversion_interval_timer} :
    hit_cfg ? {24'h00_0000, config_reg} :
    hit_st  ? status_word :
    hit_res ? result_word : 32'h0000_0000;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= read_mux;
  end
endmodule // acis_sequencer

// File: acis_pkg.sv
// package: register map, field layout and timing constants of the sequencer
package acis_pkg;
  // =====================================================================
  // register map
  localparam logic [11:0] ADDR_CYCLE_TIMER = 12'h000;
  localparam logic [11:0] ADDR_CONFIG      = 12'h004;
  localparam logic [11:0] ADDR_STATUS      = 12'h008;
  localparam logic [11:0] ADDR_RESULT      = 12'h00C;
  localparam int          ADDR_W           = 12;
  // =====================================================================
  // fields and reset values
  localparam int          NUM_CH           = 4;
  localparam int          CODE_LSB         = 0;
  localparam int          CODE_MSB         = 2;
  localparam int          CH_LSB           = 4;
  localparam int          CH_MSB           = 7;
  localparam int          RES_W            = 12;
  localparam logic [7:0]  CYCLE_RESET      = 8'h00;
  localparam logic [7:0]  CONFIG_RESET     = 8'h00;
  localparam logic [2:0]  CODE_OFF         = 3'h0;
  // =====================================================================
  // timing
  localparam int          CLK_HZ           = 20_000_000;
  localparam int          POWERUP_NS       = 1000;
  localparam int          CONV_NS          = 2000;
  localparam int          CLK_NS           = 1_000_000_000 / CLK_HZ;
  localparam int          POWERUP_CYC      = (POWERUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CONV_CYC         = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CNT_W            = 24;
  localparam int          BUSY_W           = 8;
  // =====================================================================
  // sequencer states
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE  = 2'b10,
    ST_CONV  = 2'b11
  } acis_state_e;
endpackage

// File: acis_tmr_if.sv
// interface: interval timer control between sequencer and timer
`timescale 1ns/1ps
interface acis_tmr_if;
  logic [2:0] code;
  logic       restart;
  logic       due;
  modport seq (output code, output restart, input due);
  modport tmr (input code, input restart, output due);
endinterface

// File: acis_interval_timer.sv
// module: per-code interval timer with parameter period table
`timescale 1ns/1ps
module acis_interval_timer
  import acis_pkg::*;
#(
  parameter logic [CNT_W-1:0] PERIOD_1 = 24'h00_4E20,
  parameter logic [CNT_W-1:0] PERIOD_2 = 24'h00_9C40,
  parameter logic [CNT_W-1:0] PERIOD_3 = 24'h01_3880,
  parameter logic [CNT_W-1:0] PERIOD_4 = 24'h02_7100,
  parameter logic [CNT_W-1:0] PERIOD_5 = 24'h04_E200,
  parameter logic [CNT_W-1:0] PERIOD_6 = 24'h09_C400,
  parameter logic [CNT_W-1:0] PERIOD_7 = 24'h13_8800
)
(
  input  wire logic  clk,
  input  wire logic  reset_n,
  acis_tmr_if.tmr    tmr
);
  // =====================================================================
  // period lookup
  function automatic logic [CNT_W-1:0] period_of(input logic [2:0] c);
    unique case (c)
      3'h1:    period_of = PERIOD_1;
      3'h2:    period_of = PERIOD_2;
      3'h3:    period_of = PERIOD_3;
      3'h4:    period_of = PERIOD_4;
      3'h5:    period_of = PERIOD_5;
      3'h6:    period_of = PERIOD_6;
      3'h7:    period_of = PERIOD_7;
      default: period_of = '0;
    endcase
  endfunction

  logic [CNT_W-1:0] count;
  wire  logic [CNT_W-1:0] period   = period_of(tmr.code);
  wire  logic             running  = (tmr.code != CODE_OFF);
  wire  logic             at_end   = (count >= period - 24'h00_0001);

  assign tmr.due = running && at_end && !tmr.restart;

  // =====================================================================
  // counter
  always_ff @(posedge clk)
  begin
    if (!reset_n || !running || tmr.restart || at_end)
      count <= '0;
    else
      count <= count + 24'h00_0001;
  end
endmodule // acis_interval_timer

// File: acis_conv_model.sv
// model: converter answering a start with a held done and result
`timescale 1ns/1ps
module acis_conv_model
  import acis_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             adc_power_up,
  input  wire logic             adc_start,
  input  wire logic [7:0]       delay,
  input  wire logic [RES_W-1:0] data,
  output logic                  adc_done,
  output logic      [RES_W-1:0] adc_result
);
  logic [7:0] cnt;
  initial
  begin
    cnt = 8'h00;
    adc_done = 1'b0;
    adc_result = 12'h000;
  end
  // delay zero never answers; result toggles while not valid
  always @(posedge clk)
  begin
    if (!adc_power_up)
      cnt <= 8'h00;
    else if (adc_start)
      cnt <= delay;
    else if (cnt > 8'h01)
      cnt <= cnt - 8'h01;
    adc_done <= adc_power_up && (cnt == 8'h01);
    if (cnt == 8'h01)
      adc_result <= data;
    else if (!adc_done)
      adc_result <= ~adc_result;
  end
endmodule // acis_conv_model

// File: acis_props.sv
// checker: port timing of the interval sequencer
`timescale 1ns/1ps
module acis_props
  import acis_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              adc_power_up,
  input wire logic              adc_start,
  input wire logic [1:0]        adc_channel
);
  // ==========
  // helpers
  wire acc = psel && penable;
  wire bad = (paddr[11:4] != 8'h00) || (paddr[1:0] != 2'h0);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_wake;
    $rose(adc_power_up);
  endsequence
  sequence s_off;
    acc && pwrite && paddr == ADDR_CYCLE_TIMER && !adc_power_up
      && pwdata[2:0] == CODE_OFF;
  endsequence
  // ==========
  // properties
  chk_ready_high: assert property (psel |-> pready)
    else $error("pready low");
  chk_err_map: assert property (acc |-> pslverr == bad)
    else $error("pslverr wrong");
  chk_start_pwr: assert property (adc_start |-> adc_power_up)
    else $error("start unpowered");
  chk_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("start too long");
  chk_wake_start: assert property
    (s_wake |-> !adc_start [*8] ##[1:20] adc_start)
    else $error("no start after wake");
  chk_power_down: assert property
    (adc_start |-> ##[1:100] !adc_power_up)
    else $error("no power down");
  chk_chan_hold: assert property
    (adc_power_up && $past(adc_power_up) |-> $stable(adc_channel))
    else $error("channel moved");
  chk_off_quiet: assert property (s_off |=> !adc_power_up [*8])
    else $error("woke after off");
endmodule // acis_props
bind acis_sequencer acis_props u_props
(
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .adc_power_up(adc_power_up),
  .adc_start(adc_start), .adc_channel(adc_channel)
);

// File: tb.sv
// testbench: registers and the interval conversion loop
`timescale 1ns/1ps
module tb
  import acis_pkg::*;
;
  localparam int    PER = 20000;
  logic             clk, reset_n, psel, penable, pwrite, e;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, q, rnd, xr;
  logic             pready, pslverr, adc_power_up, adc_start, adc_done;
  logic [1:0]       adc_channel, ch;
  logic [RES_W-1:0] adc_result, data;
  logic [7:0]       delay;
  logic [3:0]       mask;
  int               n_mismatch, checks_done, cyc, n_start, t0, gap;
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    n_start <= n_start + ((adc_start === 1'b1) ? 1 : 0);
  end
  acis_sequencer dut
  (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_power_up(adc_power_up),
    .adc_start(adc_start), .adc_channel(adc_channel),
    .adc_done(adc_done), .adc_result(adc_result)
  );
  acis_conv_model u_conv
  (
    .clk(clk), .adc_power_up(adc_power_up), .adc_start(adc_start),
    .delay(delay), .data(data), .adc_done(adc_done),
    .adc_result(adc_result)
  );
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // next enabled channel above c, wrapping to the lowest
  function logic [1:0] next_ch(input logic [3:0] m, input logic [1:0] c);
    logic [1:0] j;
    j = c;
    for (int i = 0; i < 4; i++)
    begin
      j = j + 2'h1;
      if (m[j])
        return j;
    end
    return c;
  endfunction
  task finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task cmp(input string what, input logic [31:0] xp, input logic [31:0] got);
    checks_done++;
    if (got !== xp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, xp, got);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    wait_on(2'h2, 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // 1: start pulse, 0: power down, 2: pready; bound runs out as mismatch
  task wait_on(input logic [1:0] w, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (n > lim)
      begin
        n_mismatch++;
        finish_test();
      end
    end
    while ((w == 2'h1 ? adc_start : w == 2'h0 ? !adc_power_up : pready)
      !== 1'b1);
  endtask
  initial
  begin
    {reset_n, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata, data, delay} = 64'h0000_0000_0000_0000;
    rnd = 32'h0000_f973;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, ADDR_CYCLE_TIMER, 32'h0000_0000);
    cmp("timer reset", {24'h00_0000, CYCLE_RESET}, q);
    apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
    cmp("config reset", {24'h00_0000, CONFIG_RESET}, q);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    cmp("unmapped err", 32'h0000_0001, {31'h0, e});
    apb(1'b0, 12'h010, 32'h0000_0000);
    cmp("unmapped data", 32'h0000_0000, q);
    rnd = lfsr(rnd);
    mask = (rnd[3:0] == 4'h0) ? 4'h9 : rnd[3:0];
    apb(1'b1, ADDR_CONFIG, {24'h00_0000, mask, 4'h0});
    apb(1'b1, ADDR_CYCLE_TIMER, 32'h0000_0001);
    apb(1'b0, ADDR_CYCLE_TIMER, 32'h0000_0000);
    cmp("timer code", 32'h0000_0001, q);
    ch = next_ch(mask, 2'h3);
    for (int k = 0; k < 3; k++)
    begin
      rnd = lfsr(rnd);
      data <= rnd[11:0];
      delay <= (k == 0) ? 8'h03 : (k == 1) ? 8'h1e : 8'h00;
      wait_on(2'h1, PER + 500);
      gap = cyc - t0;
      t0 = cyc;
      e = (gap >= PER - 2) && (gap <= PER + 120);
      if (k > 0)
        cmp("interval", 1, {31'h0, e});
      cmp("channel", {30'h0, ch}, {30'h0, adc_channel});
      wait_on(2'h0, 120);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      cmp("status", {26'h0, ST_SLEEP, ch, 2'b01}, q);
      apb(1'b0, ADDR_RESULT, 32'h0000_0000);
      if (k < 2)
        xr = {18'h0, ch, data};
      cmp("result", xr, q);
      ch = next_ch(mask, ch);
    end
    apb(1'b1, ADDR_CYCLE_TIMER, 32'h0000_0000);
    t0 = n_start;
    repeat (PER + 200) @(posedge clk);
    cmp("stopped", t0, n_start);
    finish_test();
  end
endmodule // tb
